// ==== core/touch_i2c_pkg.sv ====
/*
  Constants and carrier types for the touch sensor two-wire slave port.
  Assumes a single reference clock domain; the register file sits outside.
*/
package touch_i2c_pkg;

  // Slave addresses of the two part variants
  localparam logic [6:0] ADDR_FIRST_VARIANT  = 7'h4a;
  localparam logic [6:0] ADDR_SECOND_VARIANT = 7'h4b;

  // Register pointer layout
  localparam logic [7:0] POINTER_RESET       = 8'h00;
  localparam logic [7:0] POINTER_LAST        = 8'h44;
  localparam logic [7:0] POINTER_WRAP        = 8'h00;
  localparam logic [7:0] TOUCH_STATUS_ADDR   = 8'h00;

  // Bit counting within one byte
  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
  localparam logic [3:0] BIT_COUNT_RESET     = 4'h0;

  // Cycles after reset release before the variant strap is taken
  localparam logic [1:0] STRAP_SETTLE        = 2'h2;

  // Serial port states, Gray coded along the write path
  typedef enum logic [3:0] {
    st_idle     = 4'h0,
    st_addr     = 4'h1,
    st_addr_ack = 4'h3,
    st_cmd      = 4'h2,
    st_cmd_ack  = 4'h6,
    st_wr_data  = 4'h7,
    st_wr_ack   = 4'h5,
    st_rd_data  = 4'h4,
    st_rd_ack   = 4'hc
  } port_state_type;

  // Write request towards the register file
  typedef struct packed {
    logic       strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage

// ==== core/touch_sensor_i2c_slave_port.sv ====
/*
  Two-wire slave port of the touch sensor controller: START/STOP decode,
  address match, register pointer, byte acknowledge and the shared
  interrupt pin. Assumes pins arrive asynchronous to ref_clk and that the
  register file answers reg_read_data combinationally from reg_read_addr.
*/
`timescale 1ns/1ps

// How it works
// [RULE1] Slave only; master starts transfers and drives the clock; we never drive it.
// [RULE2] Data pin is input plus open-drain pull-low; clock pin is input only.
// [RULE3] Transfer is START, address with direction, register byte, data bytes, STOP.
// [RULE4] Idle lines high; START is data falling, STOP data rising, clock high.
// [RULE5] One bit per clock pulse; driver holds data steady while clock is high.
// [RULE6] Ninth pulse carries acknowledge; receiver holds data low through its high phase.
// [RULE7] We acknowledge bytes we receive; master acknowledges bytes we send.
// [RULE8] Seven address bits compared; eighth bit low means write, high means read.
// [RULE9] Watch for START plus own address; acknowledge it and continue.
// [RULE10] Address fixed by variant: 0x4A first, 0x4B second.
// [RULE11] First written byte after address loads the register pointer.
// [RULE12] STOP after that byte only keeps the pointer; nothing is written.
// [RULE13] First data byte is written to the register the pointer selects.
// [RULE14] Later data bytes go to following registers; pointer advances per byte.
// [RULE15] Reads come from the pointer, which advances after each byte sent.
// [RULE16] Master sets pointer by write, repeated START with read, then reads bytes.
// [RULE17] Port works up to 400 kbit/s; master stays at or below that. The bench host_model runs 125 ns pulses, 8 Mbit/s.
// [RULE18] Interrupt is active-low open drain on the pin shared with third electrode.
// [RULE19] When enabled, interrupt fires on any electrode touch status change.
// [RULE20] Pointer steps by one; after 0x44 it wraps to 0x00.
// [RULE21] With several masters the host uses repeated STARTs until its STOP.
// [RULE22] After reset the shared pin is interrupt, deasserted, driver off.
// [RULE23] On address mismatch, release data and ignore bytes until next START.
module touch_sensor_i2c_slave_port
  import touch_i2c_pkg::*;
#(
  parameter int ELECTRODES = 3
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output      logic                  sda_out,
  output      logic                  sda_oe,
  input  wire logic                  variant_select,
  input  wire logic [ELECTRODES-1:0] touch_status,
  input  wire logic                  irq_enable,
  input  wire logic                  interrupt_or_third_electrode_pin_in,
  output      logic                  interrupt_or_third_electrode_pin_out,
  output      logic                  interrupt_or_third_electrode_pin_oe,
  output      logic                  third_electrode_input,
  output      logic [7:0]            reg_read_addr,
  input  wire logic [7:0]            reg_read_data,
  output      logic                  reg_read_strobe,
  output      reg_write_type         reg_write
);

  // Pointer step with wrap after the last mapped register
  function automatic logic [7:0] next_pointer(input logic [7:0] ptr);
    next_pointer = (ptr == POINTER_LAST) ? POINTER_WRAP : ptr + 8'h01; // see [RULE20]
  endfunction

  logic           scl_meta;
  logic           scl_sync;
  logic           scl_prev;
  logic           sda_meta;
  logic           sda_sync;
  logic           sda_prev;
  logic           pin_meta;
  logic           pin_sync;
  logic           variant_meta;
  logic           variant_sync;
  logic [1:0]     strap_count;
  logic [6:0]     own_address;
  port_state_type state;
  logic [3:0]     bit_count;
  logic [7:0]     shift_in;
  logic [7:0]     tx_byte;
  logic           read_mode;
  logic           master_nack;
  logic [7:0]     pointer;
  logic [ELECTRODES-1:0] touch_prev;
  logic           irq_pending;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;
  logic           byte_end;
  logic           load_tx;
  logic           touch_change;

  // Two flip-flops on every pin before any logic looks at it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_meta     <= 1'b1;
      scl_sync     <= 1'b1;
      scl_prev     <= 1'b1;
      sda_meta     <= 1'b1;
      sda_sync     <= 1'b1;
      sda_prev     <= 1'b1;
      pin_meta     <= 1'b1;
      pin_sync     <= 1'b1;
      variant_meta <= 1'b0;
      variant_sync <= 1'b0;
    end else begin
      scl_meta     <= scl_in;                                        // see [RULE17]
      scl_sync     <= scl_meta;
      scl_prev     <= scl_sync;
      sda_meta     <= sda_in;
      sda_sync     <= sda_meta;
      sda_prev     <= sda_sync;
      pin_meta     <= interrupt_or_third_electrode_pin_in;
      pin_sync     <= pin_meta;
      variant_meta <= variant_select;
      variant_sync <= variant_meta;
    end
  end

  // Bus events; clock edges are found by sampling, the master owns the clock
  assign scl_rise   = scl_sync & ~scl_prev;                          // see [RULE1]
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;    // see [RULE4]
  assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;    // see [RULE4]
  assign byte_end   = scl_fall && (bit_count == BITS_PER_BYTE);      // see [RULE6]
  assign load_tx    = scl_fall && ((state == st_addr_ack && read_mode) ||
                                   (state == st_rd_ack && !master_nack));

  // Variant strap taken once the synchroniser has settled after release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_count <= 2'h0;
      own_address <= ADDR_FIRST_VARIANT;
    end else if (strap_count != STRAP_SETTLE) begin
      strap_count <= strap_count + 2'h1;
    end else begin
      own_address <= variant_sync ? ADDR_SECOND_VARIANT : ADDR_FIRST_VARIANT; // see [RULE10]
    end
  end

  // Byte engine; data changes only after a falling clock edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state       <= st_idle;
      bit_count   <= BIT_COUNT_RESET;
      shift_in    <= 8'h00;
      tx_byte     <= 8'h00;
      read_mode   <= 1'b0;
      master_nack <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (start_seen) begin
      state     <= st_addr;                                          // see [RULE9]
      bit_count <= BIT_COUNT_RESET;
      sda_oe    <= 1'b0;
    end else if (stop_seen) begin
      state  <= st_idle;                                             // see [RULE4]
      sda_oe <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_in  <= {shift_in[6:0], sda_sync};                      // see [RULE5]
        bit_count <= bit_count + 4'h1;
        if (state == st_rd_ack) begin
          master_nack <= sda_sync;                                   // see [RULE7]
        end
      end
      if (scl_fall) begin
        case (state)
          st_addr: begin
            if (byte_end) begin
              if (shift_in[7:1] == own_address) begin                // see [RULE8]
                state     <= st_addr_ack;
                sda_oe    <= 1'b1;                                   // see [RULE9]
                read_mode <= shift_in[0];                            // see [RULE8]
              end else begin
                state <= st_idle;                                    // see [RULE23]
              end
            end
          end
          st_cmd, st_wr_data: begin
            if (byte_end) begin
              state  <= (state == st_cmd) ? st_cmd_ack : st_wr_ack;
              sda_oe <= 1'b1;                                        // see [RULE7]
            end
          end
          st_addr_ack: begin
            bit_count <= BIT_COUNT_RESET;
            if (read_mode) begin
              state   <= st_rd_data;                                 // see [RULE15]
              tx_byte <= reg_read_data;
              sda_oe  <= ~reg_read_data[7];
            end else begin
              state  <= st_cmd;                                      // see [RULE3]
              sda_oe <= 1'b0;
            end
          end
          st_cmd_ack, st_wr_ack: begin
            state     <= st_wr_data;
            sda_oe    <= 1'b0;
            bit_count <= BIT_COUNT_RESET;
          end
          st_rd_data: begin
            if (byte_end) begin
              state  <= st_rd_ack;                                   // see [RULE7]
              sda_oe <= 1'b0;
            end else begin
              tx_byte <= {tx_byte[6:0], 1'b0};
              sda_oe  <= ~tx_byte[6];                                // see [RULE2]
            end
          end
          st_rd_ack: begin
            bit_count <= BIT_COUNT_RESET;
            if (master_nack) begin
              state <= st_idle;
            end else begin
              state   <= st_rd_data;
              tx_byte <= reg_read_data;
              sda_oe  <= ~reg_read_data[7];
            end
          end
          default: state <= state;
        endcase
      end
    end
  end

  // Open drain: the data line is only ever pulled low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;                                               // see [RULE2]
    end
  end

  // Register pointer, shared by writes and reads
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pointer <= POINTER_RESET;
    end else if (byte_end && !start_seen && !stop_seen) begin
      case (state)
        st_cmd:     pointer <= shift_in;                             // see [RULE11]
        st_wr_data: pointer <= next_pointer(pointer);                // see [RULE14]
        st_rd_data: pointer <= next_pointer(pointer);                // see [RULE15]
        default:    pointer <= pointer;
      endcase
    end
  end

  // Register file access; a command byte alone writes nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_write       <= '0;
      reg_read_addr   <= POINTER_RESET;
      reg_read_strobe <= 1'b0;
    end else begin
      reg_write.strobe <= byte_end && (state == st_wr_data) && !start_seen && !stop_seen; // see [RULE12]
      if (byte_end && state == st_wr_data) begin
        reg_write.addr <= pointer;                                   // see [RULE13]
        reg_write.data <= shift_in;
      end
      reg_read_addr   <= pointer;
      reg_read_strobe <= load_tx && !start_seen && !stop_seen;
    end
  end

  // Touch status change latches an interrupt; a set beats a same-cycle clear
  assign touch_change = (touch_status != touch_prev);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      touch_prev  <= '0;
      irq_pending <= 1'b0;
    end else begin
      touch_prev <= touch_status;
      if (touch_change) begin
        irq_pending <= 1'b1;                                         // see [RULE19]
      end else if (reg_read_strobe && reg_read_addr == TOUCH_STATUS_ADDR) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // Shared pin: interrupt pulls low when enabled, else it is the third electrode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      interrupt_or_third_electrode_pin_out <= 1'b0;
      interrupt_or_third_electrode_pin_oe  <= 1'b0;                  // see [RULE22]
      third_electrode_input                <= 1'b0;
    end else begin
      interrupt_or_third_electrode_pin_out <= 1'b0;                  // see [RULE18]
      interrupt_or_third_electrode_pin_oe  <= irq_enable && irq_pending;
      third_electrode_input                <= irq_enable ? 1'b0 : pin_sync; // see [RULE18]
    end
  end

  // Checks on the driven side of the port
  a_sda_pull_low: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE2]
    sda_out == 1'b0)
    else $error("data line driven high");
  a_addr_match_ack: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE9]
    (state == st_addr && byte_end && !start_seen && !stop_seen && shift_in[7:1] == own_address)
      |=> (state == st_addr_ack && sda_oe))
    else $error("own address not acknowledged");
  a_idle_released: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE23]
    (state == st_idle) |-> !sda_oe)
    else $error("data driven while ignoring the bus");
  a_stop_frees: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE4]
    (stop_seen && !start_seen) |=> (state == st_idle && !sda_oe))
    else $error("stop did not free the bus");
  a_start_restart: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE4]
    start_seen |=> (state == st_addr && bit_count == BIT_COUNT_RESET))
    else $error("start not taken");
  a_cmd_pointer: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE11]
    (state == st_cmd && byte_end && !start_seen && !stop_seen) |=> pointer == $past(shift_in))
    else $error("command byte not loaded");

  a_write_advance: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE14]
    (state == st_wr_data && byte_end && !start_seen && !stop_seen)
      |=> (reg_write.strobe && reg_write.addr == $past(pointer) && pointer == next_pointer($past(pointer))))
    else $error("data byte write or pointer step wrong");

  a_write_source: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE12]
    reg_write.strobe |-> ($past(state) == st_wr_data && $past(bit_count) == BITS_PER_BYTE))
    else $error("register written outside a data byte");

  a_read_advance: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE15]
    (state == st_rd_data && byte_end && !start_seen && !stop_seen)
      |=> (pointer == next_pointer($past(pointer)) && !sda_oe) ##1 reg_read_addr == pointer)
    else $error("read pointer did not advance");

  a_irq_change: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE19]
    (touch_change && irq_enable) ##1 irq_enable |-> ##[0:1] interrupt_or_third_electrode_pin_oe)
    else $error("interrupt missed a touch change");

  a_hold_high: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE5]
    ($changed(sda_oe) && !$past(start_seen) && !$past(stop_seen)) |-> !scl_sync)
    else $error("data changed while clock high");

endmodule

// ==== test/host_model.sv ====
/*
  Two-wire bus master model standing in for the host controller.
  Assumes a pull-up outside resolves the data wire from all pull-downs.
*/
`timescale 1ns/1ps
module host_model #(
  parameter real QUARTER = 31.25
) (
  output logic      scl,
  output logic      sda_pull_low,
  input  wire logic sda
);
  // Bus idles with both lines released
  initial begin
    scl          = 1'b1;
    sda_pull_low = 1'b0;
  end

  // START, or repeated START from a low clock; only we drive the clock
  task automatic bus_start();
    sda_pull_low = 1'b0;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) sda_pull_low = 1'b1;
    #(QUARTER) scl = 1'b0;
    #(QUARTER);
  endtask

  // STOP ends the transfer and frees the bus
  task automatic bus_stop();
    sda_pull_low = 1'b1;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) sda_pull_low = 1'b0;
    #(QUARTER);
  endtask

  // One pulse of 125 ns; data moves only while the clock is low
  task automatic bit_cycle(input logic drive, output logic seen);
    sda_pull_low = ~drive;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) seen = sda;
    #(QUARTER) scl = 1'b0;
    #(QUARTER);
  endtask

  // Byte out, first bit most significant, then the slave's acknowledge
  task automatic write_byte(input logic [7:0] data, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) bit_cycle(data[i], seen);
    bit_cycle(1'b1, seen);
    ack = ~seen;
  endtask

  // Byte in; we acknowledge it when ack is set, else we refuse it
  task automatic read_byte(input logic ack, output logic [7:0] data);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, seen);
      data[i] = seen;
    end
    bit_cycle(~ack, seen);
  endtask
endmodule

// ==== test/tb_touch_sensor_i2c_slave_port.sv ====
/*
  Self-checking bench for the touch sensor two-wire slave port.
  Assumes host_model as bus master and a register file stand-in held here.
*/
`timescale 1ns/1ps
module tb_touch_sensor_i2c_slave_port
  import touch_i2c_pkg::*;
;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
  } row_type;

  logic          ref_clk = 1'b0;
  logic          reset, variant_select, irq_enable, elec_level;
  logic [2:0]    touch_status;
  logic          scl, host_pull, sda_oe, sda_out, pin_oe, pin_out, third_in, read_strobe, prev_oe, prev_scl;
  logic [7:0]    read_addr;
  reg_write_type reg_write;
  logic [7:0]    mem [256];
  logic [7:0]    exp_mem [256];
  logic [15:0]   wlog [$];
  logic [6:0]    own;
  int            fails = 0;
  int            tests_run = 0;
  int            cycles = 0;
  int            reads = 0;
  wire logic     sda_wire = ~((sda_oe & ~sda_out) | host_pull);
  wire logic     pin_wire = pin_oe ? pin_out : (irq_enable | elec_level);
  row_type       rows [5] = '{'{7'h4a, 8'h10, 8'h55, 8'haa}, '{7'h4a, 8'h44, 8'h01, 8'h02},
                             '{7'h4b, 8'h20, 8'h33, 8'h44}, '{7'h25, 8'h30, 8'h66, 8'h77},
                             '{7'h4a, 8'h2d, 8'hc3, 8'h3c}};

  touch_sensor_i2c_slave_port #(.ELECTRODES(3)) i_touch_sensor_i2c_slave_port (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .variant_select(variant_select), .touch_status(touch_status), .irq_enable(irq_enable),
    .interrupt_or_third_electrode_pin_in(pin_wire), .interrupt_or_third_electrode_pin_out(pin_out),
    .interrupt_or_third_electrode_pin_oe(pin_oe), .third_electrode_input(third_in),
    .reg_read_addr(read_addr), .reg_read_data(mem[read_addr]), .reg_read_strobe(read_strobe), .reg_write(reg_write)
  );

  host_model i_host_model (.scl(scl), .sda_pull_low(host_pull), .sda(sda_wire));

  always #2 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Register file stand-in; answers reads at once and logs every write
  // Sampled mid-cycle so a strobe is never read in the step that launches it
  always @(negedge ref_clk) begin
    if (reg_write.strobe === 1'b1) begin
      mem[reg_write.addr] <= reg_write.data;
      wlog.push_back({reg_write.addr, reg_write.data});
    end
    if (read_strobe === 1'b1) reads <= reads + 1;
  end

  // Device side of the wires: pull-low only, data steady while clock high
  always @(negedge ref_clk) begin
    if (!reset && prev_scl === 1'b1 && scl === 1'b1 && sda_oe !== prev_oe) begin
      check("sda_hold", sda_oe, prev_oe);
    end
    if (sda_oe === 1'b1 && sda_out !== 1'b0) check("sda_drive", sda_out, 1'b0);
    if (pin_oe === 1'b1 && pin_out !== 1'b0) check("pin_drive", pin_out, 1'b0);
    prev_oe  <= sda_oe;
    prev_scl <= scl;
  end

  // Cut a hang short; the sequence needs about a third of this
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end

  function automatic logic [7:0] step(input logic [7:0] p);
    return (p == POINTER_LAST) ? POINTER_WRAP : p + 8'h01;
  endfunction

  // START plus address byte; the fraction keeps link edges off ref_clk edges
  task automatic address(input logic [6:0] a, input logic rw, output logic ack);
    @(negedge ref_clk);
    #0.3;
    i_host_model.bus_start();
    i_host_model.write_byte({a, rw}, ack);
  endtask

  // Load the pointer, repeated START, read n bytes and compare
  task automatic read_regs(input logic [7:0] p, input int n);
    logic       ack;
    logic [7:0] d;
    int         base;
    base = reads;
    address(own, 1'b0, ack);
    i_host_model.write_byte(p, ack);
    address(own, 1'b1, ack);
    check("read_addr_ack", ack, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_host_model.read_byte(k < n - 1, d);
      check("read_data", d, exp_mem[p]);
      p = step(p);
    end
    i_host_model.bus_stop();
    // One register fetch per byte sent; the closing refusal fetches nothing
    check("read_strobes", 16'(reads - base), 16'(n));
  endtask

  initial begin
    logic       ack, a0, a1, a2;
    logic [7:0] d;
    reset          = 1'b1;
    variant_select = 1'b0;
    irq_enable     = 1'b1;
    elec_level     = 1'b1;
    touch_status   = 3'h0;
    own            = ADDR_FIRST_VARIANT;
    for (int i = 0; i < 256; i++) begin
      mem[i]     = 8'(i) ^ 8'h5a;
      exp_mem[i] = 8'(i) ^ 8'h5a;
    end
    repeat (16) @(negedge ref_clk);
    check("reset_outputs", {sda_oe, pin_oe, reg_write.strobe}, 3'h0);
    reset = 1'b0;
    repeat (8) @(negedge ref_clk);
    // Ordinary writes: matching, wrapping and foreign addresses
    foreach (rows[r]) begin
      wlog.delete();
      address(rows[r].a, 1'b0, ack);
      check("addr_ack", ack, rows[r].a == own);
      i_host_model.write_byte(rows[r].cmd, a0);
      i_host_model.write_byte(rows[r].d0, a1);
      i_host_model.write_byte(rows[r].d1, a2);
      i_host_model.bus_stop();
      check("data_acks", {a0, a1, a2}, {3{rows[r].a == own}});
      check("write_count", 16'(wlog.size()), (rows[r].a == own) ? 16'h0002 : 16'h0000);
      if (rows[r].a == own) begin
        check("write_first", wlog[0], {rows[r].cmd, rows[r].d0});
        check("write_next", wlog[1], {step(rows[r].cmd), rows[r].d1});
        exp_mem[rows[r].cmd]       = rows[r].d0;
        exp_mem[step(rows[r].cmd)] = rows[r].d1;
      end
    end
    // Command byte alone only moves the pointer; a bare read starts there
    wlog.delete();
    address(own, 1'b0, ack);
    i_host_model.write_byte(8'h2a, ack);
    i_host_model.bus_stop();
    check("cmd_only_writes", 16'(wlog.size()), 16'h0000);
    address(own, 1'b1, ack);
    i_host_model.read_byte(1'b0, d);
    i_host_model.bus_stop();
    check("kept_pointer", d, exp_mem[8'h2a]);
    read_regs(8'h43, 3);
    // Status change raises the shared pin low; status read clears it
    @(negedge ref_clk);
    touch_status = 3'h2;
    repeat (4) @(negedge ref_clk);
    check("irq_set", {pin_oe, pin_wire, third_in}, 3'h4);
    read_regs(TOUCH_STATUS_ADDR, 1);
    check("irq_clear", pin_oe, 1'b0);
    // Interrupt off: the pin turns into the third electrode input
    @(negedge ref_clk);
    irq_enable   = 1'b0;
    touch_status = 3'h0;
    elec_level   = 1'b0;
    repeat (6) @(negedge ref_clk);
    check("electrode_low", {pin_oe, third_in}, 2'h0);
    elec_level = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("electrode_high", third_in, 1'b1);
    // Second variant after a fresh reset
    reset          = 1'b1;
    variant_select = 1'b1;
    irq_enable     = 1'b1;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    own   = ADDR_SECOND_VARIANT;
    repeat (8) @(negedge ref_clk);
    address(ADDR_FIRST_VARIANT, 1'b0, ack);
    i_host_model.bus_stop();
    check("variant_other", ack, 1'b0);
    read_regs(8'h10, 2);
    test_done();
  end
endmodule
